// File: rtl/dfm_top.v
// Output formatting and mode control of a dual 12-bit converter
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defs.vh"
module dfm_top #(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
) (
    input  wire        clk_i,                     // 125 MHz clock
    input  wire        rst_i,                     // Sync reset, high
    input  wire        enc_clk_i,                 // Encode clock pin
    input  wire        programming_mode_select_i, // Pin: 1 parallel, 0 serial
    input  wire        cs_pin_i,                  // Chip select pin
    input  wire        sck_pin_i,                 // Serial clock pin
    input  wire        sdi_pin_i,                 // Data-input pin
    input  wire        sdo_pin_i,                 // Data-output pin as input
    input  wire [7:0]  format_power_register_i,   // Serial format/power value
    input  wire [7:0]  output_mode_register_i,    // Serial output mode value
    input  wire [7:0]  pattern_register_high_i,   // Pattern enable and top bits
    input  wire [7:0]  pattern_register_low_i,    // Pattern low bits
    input  wire [11:0] ch1_code_i,                // Channel 1 core code
    input  wire        ch1_ovr_pos_i,             // Channel 1 over positive
    input  wire        ch1_ovr_neg_i,             // Channel 1 over negative
    input  wire [11:0] ch2_code_i,                // Channel 2 core code
    input  wire        ch2_ovr_pos_i,             // Channel 2 over positive
    input  wire        ch2_ovr_neg_i,             // Channel 2 over negative
    output reg  [13:0] ch1_word_o,                // Channel 1 formatted word
    output reg  [13:0] ch2_word_o,                // Channel 2 formatted word
    output wire        word_valid_o,              // Word available
    input  wire        word_ready_i,              // Serializer takes word
    output reg         frame_marker_out_o,        // Pulse per word sent
    output reg         data_clock_out_o,          // Divided data clock
    output reg         drive_on_o,                // Output drivers powered
    output reg  [2:0]  drive_current_o,           // Current code
    output reg         drive_double_o,            // Current doubled
    output reg         term_on_o,                 // Internal termination
    output reg         two_lanes_o,               // 1: two lanes
    output reg  [1:0]  ser_bits_o,                // Serialization width
    output reg         sleep_o,                   // Whole chip down
    output reg         nap_ch1_o,                 // Channel 1 napping
    output reg         nap_ch2_o,                 // Channel 2 napping
    output reg         dcs_on_o,                  // Duty stabilizer on
    output reg         overrun_o                  // Sample dropped, FIFO full
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    reg  [5:0] pin_meta;
    reg  [5:0] pin_sync;
    reg        enc_prev;
    wire       enc_rise;
    wire       par_mode;

    // Two-stage capture of asynchronous pins
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
            enc_prev <= 1'b0;
        end else begin
            pin_meta <= {enc_clk_i, programming_mode_select_i, cs_pin_i,
                         sck_pin_i, sdi_pin_i, sdo_pin_i};
            pin_sync <= pin_meta;
            enc_prev <= pin_sync[5];
        end
    end

    assign enc_rise = pin_sync[5] & ~enc_prev;
    assign par_mode = pin_sync[4];

    // ************************************************************
    // Mode decode
    // ************************************************************
    reg        next_twos;
    reg        next_rand;
    reg        next_pat_en;
    reg        next_outoff;
    reg        next_term;
    reg [2:0]  next_current;
    reg        next_two_lanes;
    reg [1:0]  next_ser;
    reg        next_sleep;
    reg        next_nap1;
    reg        next_nap2;
    reg        next_dcs;
    reg [2:0]  omode;

    // Effective settings from pins or serial registers
    always @* begin
        omode = output_mode_register_i[`DFM_OM_MODE_HI:`DFM_OM_MODE_LO];
        if (par_mode) begin
            next_two_lanes = ~pin_sync[3];
            next_ser       = pin_sync[3] ? `DFM_SER_14 : `DFM_SER_16;
            next_current   = pin_sync[2] ? `DFM_ILVDS_1P75 : `DFM_ILVDS_3P5;
            next_sleep     = pin_sync[1];
            next_term      = pin_sync[0];
            next_dcs       = 1'b1;
            next_twos      = 1'b0;
            next_rand      = 1'b0;
            next_pat_en    = 1'b0;
            next_outoff    = 1'b0;
            next_nap1      = 1'b0;
            next_nap2      = 1'b0;
        end else begin
            next_twos      = format_power_register_i[`DFM_FP_TWOS];
            next_rand      = format_power_register_i[`DFM_FP_RAND];
            next_dcs       = ~format_power_register_i[`DFM_FP_DCSOFF];
            next_sleep     = format_power_register_i[`DFM_FP_SLEEP];
            next_nap1      = format_power_register_i[`DFM_FP_NAP1];
            next_nap2      = format_power_register_i[`DFM_FP_NAP2];
            next_pat_en    = pattern_register_high_i[`DFM_PH_PAT_EN];
            next_outoff    = output_mode_register_i[`DFM_OM_OUTOFF];
            next_term      = output_mode_register_i[`DFM_OM_TERM];
            next_current   = output_mode_register_i[`DFM_OM_ILVDS_HI:`DFM_OM_ILVDS_LO];
            next_two_lanes = (omode == `DFM_MODE_2L16) || (omode == `DFM_MODE_2L14) ||
                             (omode == `DFM_MODE_2L12);
            case (omode)
                `DFM_MODE_2L16, `DFM_MODE_1L16: next_ser = `DFM_SER_16;
                `DFM_MODE_2L14, `DFM_MODE_1L14: next_ser = `DFM_SER_14;
                default:                        next_ser = `DFM_SER_12;
            endcase
        end
    end

    // Registered mode state
    reg pat_en;
    reg twos;
    reg rand_on;

    always @(posedge clk_i) begin
        if (rst_i) begin
            twos            <= 1'b0;
            rand_on         <= 1'b0;
            pat_en          <= 1'b0;
            drive_on_o      <= 1'b0;
            drive_current_o <= `DFM_ILVDS_3P5;
            drive_double_o  <= 1'b0;
            term_on_o       <= 1'b0;
            two_lanes_o     <= 1'b1;
            ser_bits_o      <= `DFM_SER_16;
            sleep_o         <= 1'b0;
            nap_ch1_o       <= 1'b0;
            nap_ch2_o       <= 1'b0;
            dcs_on_o        <= 1'b1;
        end else begin
            twos            <= next_twos;
            rand_on         <= next_rand;
            pat_en          <= next_pat_en;
            // disable or sleep stops all drivers
            drive_on_o      <= ~next_outoff & ~next_sleep;
            drive_current_o <= next_current;
            drive_double_o  <= next_term;
            term_on_o       <= next_term;
            two_lanes_o     <= next_two_lanes;
            ser_bits_o      <= next_ser;
            sleep_o         <= next_sleep;
            nap_ch1_o       <= next_nap1 & ~next_sleep;
            nap_ch2_o       <= next_nap2 & ~next_sleep;
            dcs_on_o        <= next_dcs;
        end
    end

    // ************************************************************
    // Sample formatting
    // ************************************************************
    wire        fifo_in_ready;
    reg         fmt_loaded;
    wire        load;
    wire        extra_en;
    wire [13:0] pattern;
    wire [13:0] ch1_fmt;
    wire [13:0] ch2_fmt;

    assign load     = enc_rise & ~sleep_o;
    assign extra_en = (ser_bits_o != `DFM_SER_12);
    assign pattern  = {pattern_register_high_i[`DFM_PH_PAT_HI:0], pattern_register_low_i};

    dfm_chan_fmt u_fmt1 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (load),
        .code_i     (ch1_code_i),
        .ovr_pos_i  (ch1_ovr_pos_i),
        .ovr_neg_i  (ch1_ovr_neg_i),
        .nap_i      (nap_ch1_o),
        .twos_i     (twos),
        .rand_i     (rand_on),
        .extra_en_i (extra_en),
        .pat_en_i   (pat_en),
        .pattern_i  (pattern),
        .word_o     (ch1_fmt)
    );

    dfm_chan_fmt u_fmt2 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (load),
        .code_i     (ch2_code_i),
        .ovr_pos_i  (ch2_ovr_pos_i),
        .ovr_neg_i  (ch2_ovr_neg_i),
        .nap_i      (nap_ch2_o),
        .twos_i     (twos),
        .rand_i     (rand_on),
        .extra_en_i (extra_en),
        .pat_en_i   (pat_en),
        .pattern_i  (pattern),
        .word_o     (ch2_fmt)
    );

    // Formatted pair offered to FIFO for one cycle; dropped and flagged as overrun if full
    always @(posedge clk_i) begin
        if (rst_i) begin
            fmt_loaded <= 1'b0;
            overrun_o  <= 1'b0;
        end else begin
            fmt_loaded <= load;
            overrun_o  <= fmt_loaded & ~fifo_in_ready;
        end
    end

    // ************************************************************
    // Output FIFO and word stage
    // ************************************************************
    wire        fifo_out_valid;
    wire        fifo_out_ready;
    wire [27:0] fifo_out_data;
    reg         out_full;
    wire        take;

    assign word_valid_o   = out_full & drive_on_o;
    assign take           = word_valid_o & word_ready_i;
    assign fifo_out_ready = ~out_full | take;

    dfm_fifo #(
        .WIDTH (28),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fmt_loaded),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({ch1_fmt, ch2_fmt}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out_data)
    );

    // Output word registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_full   <= 1'b0;
            ch1_word_o <= 14'h0000;
            ch2_word_o <= 14'h0000;
        end else if (fifo_out_ready) begin
            out_full <= fifo_out_valid;
            if (fifo_out_valid) begin
                ch1_word_o <= fifo_out_data[27:14];
                ch2_word_o <= fifo_out_data[13:0];
            end
        end
    end

    // ************************************************************
    // Data clock and frame marker
    // ************************************************************
    reg [1:0] dco_cnt;
    wire      dco_tick;
    localparam [31:0] DCO_LAST = `DFM_DCO_DIV - 1;
    assign dco_tick = (dco_cnt == DCO_LAST[1:0]);

    always @(posedge clk_i) begin
        if (rst_i) begin
            dco_cnt            <= 2'h0;
            data_clock_out_o   <= 1'b0;
            frame_marker_out_o <= 1'b0;
        end else begin
            dco_cnt <= dco_tick ? 2'h0 : dco_cnt + 2'h1;
            if (!drive_on_o) begin
                data_clock_out_o <= 1'b0;
            end else if (dco_tick) begin
                data_clock_out_o <= ~data_clock_out_o;
            end
            frame_marker_out_o <= take;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dfm_defs.vh
// Constants for the dual converter output formatting block
`ifndef DFM_DEFS_VH
`define DFM_DEFS_VH

// Format and power register fields
`define DFM_FP_DCSOFF     7
`define DFM_FP_RAND       6
`define DFM_FP_TWOS       5
`define DFM_FP_SLEEP      4
`define DFM_FP_NAP2       3
`define DFM_FP_NAP1       0
// Output mode register fields
`define DFM_OM_ILVDS_HI   7
`define DFM_OM_ILVDS_LO   5
`define DFM_OM_TERM       4
`define DFM_OM_OUTOFF     3
`define DFM_OM_MODE_HI    2
`define DFM_OM_MODE_LO    0
// Pattern register high fields
`define DFM_PH_PAT_EN     7
`define DFM_PH_PAT_HI     5
// Driver current codes
`define DFM_ILVDS_3P5     3'h0
`define DFM_ILVDS_1P75    3'h7
// Serialization widths
`define DFM_SER_16        2'h0
`define DFM_SER_14        2'h1
`define DFM_SER_12        2'h2
// Output mode codes
`define DFM_MODE_2L16     3'h0
`define DFM_MODE_2L14     3'h1
`define DFM_MODE_2L12     3'h2
`define DFM_MODE_1L16     3'h3
`define DFM_MODE_1L14     3'h4
`define DFM_MODE_1L12     3'h5
// Sample codes
`define DFM_CODE_FULL     12'hfff
`define DFM_CODE_ZERO     12'h000
// Reset values
`define DFM_REG_RESET     8'h00
// Data clock divider count
`define DFM_DCO_DIV       2

`endif

// File: rtl/dfm_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dfm_fifo #(
    parameter WIDTH = 28,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_i,        // Clock
    input  wire             rst_i,        // Sync reset
    input  wire             in_valid_i,   // Write request
    output wire             in_ready_o,   // Not full
    input  wire [WIDTH-1:0] in_data_i,    // Write data
    output wire             out_valid_o,  // Not empty
    input  wire             out_ready_i,  // Read accept
    output wire [WIDTH-1:0] out_data_o    // Head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            do_wr;
    wire            do_rd;

    // Honest flags
    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o  = mem[rd_ptr];
    assign do_wr       = in_valid_i & in_ready_o;
    assign do_rd       = out_valid_o & out_ready_i;

    // Storage write
    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers and fill level
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr & ~do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd & ~do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/dfm_chan_fmt.v
// Per-channel sample formatter: clamp, coding, randomizer, pattern
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defs.vh"
module dfm_chan_fmt (
    input  wire        clk_i,       // Clock
    input  wire        rst_i,       // Sync reset
    input  wire        load_i,      // Take a new sample
    input  wire [11:0] code_i,      // Offset binary core code
    input  wire        ovr_pos_i,   // Above positive full scale
    input  wire        ovr_neg_i,   // Below negative full scale
    input  wire        nap_i,       // Channel napping
    input  wire        twos_i,      // Two's complement coding
    input  wire        rand_i,      // Randomizer on
    input  wire        extra_en_i,  // 14/16-bit serialization
    input  wire        pat_en_i,    // Test pattern on
    input  wire [13:0] pattern_i,   // Pattern {dx,dy,bits}
    output reg  [13:0] word_o       // Formatted {dx,dy,bits}
);
    reg [11:0] clamped;
    reg [11:0] coded;
    reg [11:0] randed;
    reg [1:0]  extra;
    reg [13:0] next_word;

    // Formatting chain for one sample
    always @* begin
        if (ovr_pos_i) begin
            clamped = `DFM_CODE_FULL;
        end else if (ovr_neg_i) begin
            clamped = `DFM_CODE_ZERO;
        end else begin
            clamped = code_i;
        end
        coded = twos_i ? {~clamped[11], clamped[10:0]} : clamped;
        randed = rand_i ? {coded[11:1] ^ {11{coded[0]}}, coded[0]} : coded;
        extra = (ovr_pos_i & extra_en_i) ? 2'h3 : 2'h0;
        if (pat_en_i) begin
            next_word = pattern_i;
        end else if (nap_i) begin
            next_word = 14'h0000;
        end else begin
            next_word = {extra, randed};
        end
    end

    // Output register
    always @(posedge clk_i) begin
        if (rst_i) begin
            word_o <= 14'h0000;
        end else if (load_i) begin
            word_o <= next_word;
        end
    end
endmodule
`default_nettype wire

// File: tb/dfm_top_chk.sv
// Port assertions for the output formatting block
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defs.vh"
module dfm_top_chk (
    input wire logic       clk_i,                     // Clock
    input wire logic       rst_i,                     // Sync reset
    input wire logic       programming_mode_select_i, // Pin mode select
    input wire logic       cs_pin_i,                  // Lane pin
    input wire logic       sck_pin_i,                 // Current pin
    input wire logic       sdi_pin_i,                 // Sleep pin
    input wire logic       sdo_pin_i,                 // Termination pin
    input wire logic [7:0] format_power_register_i,   // Format value
    input wire logic       word_valid_o,              // Word offered
    input wire logic       word_ready_i,              // Word taken
    input wire logic       frame_marker_out_o,        // Frame pulse
    input wire logic       data_clock_out_o,          // Data clock
    input wire logic       drive_on_o,                // Drivers on
    input wire logic [2:0] drive_current_o,           // Current code
    input wire logic       drive_double_o,            // Doubled current
    input wire logic       term_on_o,                 // Termination
    input wire logic       two_lanes_o,               // Lane count
    input wire logic [1:0] ser_bits_o,                // Serialization
    input wire logic       sleep_o,                   // Sleep
    input wire logic       nap_ch1_o,                 // Nap channel 1
    input wire logic       nap_ch2_o,                 // Nap channel 2
    input wire logic       dcs_on_o                   // Stabilizer on
);
    wire par = programming_mode_select_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_term_double: assert property (drive_double_o == term_on_o)
        else $error("double current differs from termination");
    a_par_fixed: assert property (par [*5] |-> dcs_on_o && !nap_ch1_o && !nap_ch2_o)
        else $error("pin mode left stabilizer off or nap on");
    // Lane pin picks lanes and width
    a_par_lanes: assert property ((par && $stable(cs_pin_i)) [*5] |->
        two_lanes_o == !cs_pin_i && ser_bits_o == (cs_pin_i ? `DFM_SER_14 : `DFM_SER_16))
        else $error("lane pin not followed");
    a_par_current: assert property ((par && $stable(sck_pin_i)) [*5] |->
        drive_current_o == (sck_pin_i ? `DFM_ILVDS_1P75 : `DFM_ILVDS_3P5))
        else $error("current pin not followed");
    // Data pins pick sleep and termination
    a_par_pins: assert property ((par && $stable({sdi_pin_i, sdo_pin_i})) [*5] |->
        sleep_o == sdi_pin_i && term_on_o == sdo_pin_i)
        else $error("sleep or termination pin not followed");
    a_ser_power: assert property (!par [*5] |-> sleep_o == $past(format_power_register_i[4])
        && nap_ch1_o == ($past(format_power_register_i[0]) && !$past(format_power_register_i[4]))
        && nap_ch2_o == ($past(format_power_register_i[3]) && !$past(format_power_register_i[4])))
        else $error("sleep or nap not following format value");
    a_off_quiet: assert property (!drive_on_o [*2] |->
        !word_valid_o && !data_clock_out_o && !frame_marker_out_o)
        else $error("output active while drivers off");
    a_frame_follows: assert property (frame_marker_out_o == $past(word_valid_o && word_ready_i))
        else $error("frame pulse not tied to accepted word");
    a_dco_runs: assert property (drive_on_o [*3] |-> data_clock_out_o != $past(data_clock_out_o, 2))
        else $error("data clock stopped while drivers on");
    a_sleep_off: assert property (sleep_o [*2] |-> !drive_on_o)
        else $error("drivers on during sleep");

    c_take: cover property (word_valid_o && word_ready_i);
    c_par_sleep: cover property (par && sleep_o);
    c_nap_one: cover property (nap_ch1_o && !nap_ch2_o);
endmodule
`default_nettype wire

// File: tb/dfm_rx_model.sv
// Receiving logic model that accepts formatted words
`timescale 1ns/1ps
`default_nettype none
module dfm_rx_model (
    input  wire logic        clk_i,    // Clock
    input  wire logic        rst_i,    // Sync reset
    input  wire logic        valid_i,  // Word offered
    input  wire logic [13:0] w1_i,     // Channel 1 word
    input  wire logic [13:0] w2_i,     // Channel 2 word
    input  wire logic        stall_i,  // Hold off acceptance
    input  wire logic        derand_i, // Undo randomizing
    output logic             ready_o,  // Accepting
    output logic [13:0]      d1_o,     // Last channel 1 sample
    output logic [13:0]      d2_o,     // Last channel 2 sample
    output logic [15:0]      cnt_o     // Words accepted
);
    assign ready_o = !stall_i;

    function automatic logic [13:0] dec(input logic [13:0] w);
        dec = derand_i ? {w[13:12], w[11:1] ^ {11{w[0]}}, w[0]} : w;
    endfunction

    // Capture on each accepted word
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_o <= 16'h0000;
        end else if (valid_i && ready_o) begin
            d1_o <= dec(w1_i);
            d2_o <= dec(w2_i);
            cnt_o <= cnt_o + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// File: tb/dfm_top_bench.sv
// Self-checking bench for the output formatting block
`timescale 1ns/1ps
`default_nettype none
`include "dfm_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module dfm_top_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        enc, par, cs, sck, sdi, sdo, stall, derand, p1, n1, p2, n2;
    logic [7:0]  fp, om, ph, pl;
    logic [11:0] c1, c2;
    logic [13:0] w1, w2, d1, d2;
    logic        vld, rdy, fr, data_clock_out, don, dbl, term, lanes, slp, nap1, nap2, dcs, ovr;
    logic [2:0]  cur;
    logic [1:0]  ser;
    logic [15:0] cnt;
    int          err_total = 0;
    int          samples_checked = 0;
    int          ovr_seen = 0;

    dfm_top uut (.clk_i, .rst_i, .enc_clk_i(enc), .programming_mode_select_i(par),
        .cs_pin_i(cs), .sck_pin_i(sck), .sdi_pin_i(sdi), .sdo_pin_i(sdo),
        .format_power_register_i(fp), .output_mode_register_i(om),
        .pattern_register_high_i(ph), .pattern_register_low_i(pl),
        .ch1_code_i(c1), .ch1_ovr_pos_i(p1), .ch1_ovr_neg_i(n1), .ch2_code_i(c2),
        .ch2_ovr_pos_i(p2), .ch2_ovr_neg_i(n2), .ch1_word_o(w1), .ch2_word_o(w2),
        .word_valid_o(vld), .word_ready_i(rdy), .frame_marker_out_o(fr),
        .data_clock_out_o(data_clock_out), .drive_on_o(don), .drive_current_o(cur),
        .drive_double_o(dbl), .term_on_o(term), .two_lanes_o(lanes), .ser_bits_o(ser),
        .sleep_o(slp), .nap_ch1_o(nap1), .nap_ch2_o(nap2), .dcs_on_o(dcs), .overrun_o(ovr));
    dfm_rx_model rx (.clk_i, .rst_i, .valid_i(vld), .w1_i(w1), .w2_i(w2), .stall_i(stall),
        .derand_i(derand), .ready_o(rdy), .d1_o(d1), .d2_o(d2), .cnt_o(cnt));

    // Clock and overrun pulse counting
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) if (ovr === 1'b1) ovr_seen++;

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic cfg(input logic [7:0] f, input logic [7:0] o, input logic [7:0] h);
        {fp, om, ph} = {f, o, h};
        tick(4);
    endtask
    // One encode period of 160 ns with both channel inputs
    task automatic send(input logic [11:0] a, input logic [1:0] oa, input logic [11:0] b,
                        input logic [1:0] ob);
        {c1, p1, n1, c2, p2, n2} = {a, oa, b, ob};
        enc = 1'b1;
        tick(10);
        enc = 1'b0;
        tick(10);
    endtask
    task automatic got(input logic [13:0] e1, input logic [13:0] e2);
        `CHK({d1, d2}, {e1, e2})
    endtask
    task automatic t_coding();
        for (int m = 0; m < 6; m++) begin
            cfg(8'h00, 8'(m), 8'h00);
            send(12'h000, 2'b10, 12'h123, 2'b00);
            // Extra bits only in wide modes
            got((m == 2 || m == 5) ? 14'h0fff : 14'h3fff, 14'h0123);
        end
        cfg(8'h00, 8'h00, 8'h00);
        send(12'h800, 2'b00, 12'h9ab, 2'b01);
        got(14'h0800, 14'h0000);
        cfg(8'h20, 8'h00, 8'h00);
        send(12'h800, 2'b00, 12'h123, 2'b10);
        got(14'h0000, 14'h37ff);
        send(12'h7ff, 2'b00, 12'h5a5, 2'b01);
        got(14'h0fff, 14'h0800);
    endtask
    task automatic t_rand();
        cfg(8'h40, 8'h00, 8'h00);
        send(12'h801, 2'b00, 12'h6b4, 2'b00);
        got(14'h07ff, 14'h06b4);
        derand = 1'b1;
        send(12'h801, 2'b00, 12'h6b4, 2'b00);
        got(14'h0801, 14'h06b4);
        derand = 1'b0;
    endtask
    task automatic t_pattern();
        pl = 8'h3c;
        cfg(8'h60, 8'h00, 8'h95);
        send(12'h123, 2'b10, 12'h456, 2'b01);
        got(14'h153c, 14'h153c);
        pl = 8'h00;
    endtask
    task automatic t_nap();
        cfg(8'h01, 8'h00, 8'h00);
        `CHK({nap1, nap2}, 2'b10)
        send(12'h321, 2'b00, 12'h321, 2'b00);
        got(14'h0000, 14'h0321);
        cfg(8'h00, 8'h00, 8'h00);
        tick(20 * 100); // 100 encode periods
        send(12'h321, 2'b00, 12'h321, 2'b00);
        got(14'h0321, 14'h0321);
    endtask
    task automatic t_off();
        logic [15:0] n0;
        cfg(8'h10, 8'h00, 8'h00);
        n0 = cnt;
        send(12'h111, 2'b00, 12'h222, 2'b00);
        `CHK({slp, don, cnt}, {2'b10, n0})
        cfg(8'h00, 8'h08, 8'h00);
        send(12'h333, 2'b00, 12'h444, 2'b00);
        `CHK({don, vld, cnt}, {2'b00, n0})
        cfg(8'h00, 8'h00, 8'h00);
        tick(10);
        `CHK({cnt, d1, d2}, {n0 + 16'h0001, 14'h0333, 14'h0444})
    endtask
    // Fill the buffer against a stalled receiver, then drain
    task automatic t_fifo();
        logic [15:0] n0;
        n0 = cnt;
        ovr_seen = 0;
        stall = 1'b1;
        for (int i = 0; i < 12; i++) send(12'(i), 2'b00, 12'h000, 2'b00);
        stall = 1'b0;
        tick(30);
        `CHK({ovr_seen > 0, 32'(cnt - n0) + ovr_seen}, {1'b1, 32'd12})
        `CHK(d1, 14'(cnt - n0 - 16'h0001))
    endtask
    task automatic t_par();
        cfg(8'h00, 8'hf0, 8'h00);
        `CHK({cur, term, dbl}, 5'h1f)
        cfg(8'ha9, 8'h08, 8'h95);
        {par, cs, sck, sdi, sdo} = 5'b11101;
        tick(6);
        `CHK({lanes, ser, cur, term, dbl, dcs, nap1, nap2, don, slp}, {1'b0, `DFM_SER_14, `DFM_ILVDS_1P75, 7'b1110010})
        send(12'h800, 2'b00, 12'h800, 2'b00);
        got(14'h0800, 14'h0800);
        {cs, sck, sdi, sdo} = 4'b0010;
        tick(6);
        `CHK({lanes, ser, cur, term, dbl, dcs, nap1, nap2, don, slp}, {1'b1, `DFM_SER_16, `DFM_ILVDS_3P5, 7'b0010001})
        {par, sdi} = 2'b00;
    endtask
    task automatic close_out();
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {enc, par, cs, sck, sdi, sdo, stall, derand, p1, n1, p2, n2} = 12'h000;
        {fp, om, ph, pl, c1, c2} = 56'h0;
        tick(5);
        rst_i = 1'b0;
        tick(3);
        t_coding();
        t_rand();
        t_pattern();
        t_nap();
        t_off();
        t_fifo();
        t_par();
        close_out();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        err_total++;
        close_out();
    end
endmodule
bind dfm_top dfm_top_chk chk (.clk_i, .rst_i, .programming_mode_select_i, .cs_pin_i,
    .sck_pin_i, .sdi_pin_i, .sdo_pin_i, .format_power_register_i, .word_valid_o,
    .word_ready_i, .frame_marker_out_o, .data_clock_out_o, .drive_on_o, .drive_current_o,
    .drive_double_o, .term_on_o, .two_lanes_o, .ser_bits_o, .sleep_o, .nap_ch1_o,
    .nap_ch2_o, .dcs_on_o);
`default_nettype wire
